/* verilog/fph_pkg.sv */
// constants shared by the flash program/erase host controller
package fph_pkg;
	// clock rate and derived bus-cycle counts
	localparam int CLK_MHZ = 20;
	localparam int WP_NS = 60;
	localparam int WPH_NS = 30;
	localparam int ACC_NS = 120;
	localparam int OEH_NS = 30;
	localparam int BUSY_NS = 200;
	localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
	localparam int WPH_CYC = (WPH_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int OEH_CYC = (OEH_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;
	// typical figures only; completion is always found by polling
	localparam int PROG_BYTE_TYP_US = 5;
	localparam int PROG_WORD_TYP_US = 7;
	localparam int ERASE_TYP_MS = 700;
	// worst-case limits; longest times convert exactly to cycles
	localparam int PROG_BYTE_MAX_US = 300;
	localparam int PROG_WORD_MAX_US = 360;
	localparam int ERASE_MAX_S = 15;
	localparam int PROG_BYTE_MAX_CYC = PROG_BYTE_MAX_US * CLK_MHZ;
	localparam int PROG_WORD_MAX_CYC = PROG_WORD_MAX_US * CLK_MHZ;
	localparam int ERASE_MAX_CYC = ERASE_MAX_S * CLK_MHZ * 1000000;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	// control fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_BYPASS = 2;
	localparam int CTRL_CE_STROBE = 3;
	localparam int CTRL_WORD = 4;
	localparam int CTRL_PROTECT = 5;
	localparam int CTRL_UNPROTECT = 6;
	localparam int CTRL_W = 7;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROG = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h3;
	// status fields: sticky events low, live state high
	localparam int STAT_DONE = 0;
	localparam int STAT_TMO = 1;
	localparam int STAT_MISMATCH = 2;
	localparam int STAT_W = 3;
	localparam int STAT_BUSY = 8;
	localparam int STAT_RDY = 9;
	// data and address bit positions
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int PROT_SEL_BIT = 6;
	localparam int PROT_HIGH_BIT = 1;
	localparam int PROT_LOW_BIT = 0;
	// command sequence address kinds
	localparam logic [1:0] AK_UNLOCK1 = 2'h0;
	localparam logic [1:0] AK_UNLOCK2 = 2'h1;
	localparam logic [1:0] AK_TARGET = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_WRECOV, ST_BUSYWAIT, ST_RSTROBE, ST_RGAP
	} fph_state_t;
endpackage

/* verilog/fph_flash_host.sv */
// host controller that programs, erases and polls a parallel nor flash
`timescale 1ns/10ps
// What the device does and what this block does
// RQ1: device preprograms every byte of a region to zero before erasing it.
// RQ2: suspend toggle bit toggles only when read inside an erase-suspended sector.
// RQ3: toggle bits advance on chip-enable or output-enable cycling between status reads.
// RQ4: protect cycles hold address bit one high, bit zero low; bit six selects.
// RQ5: program takes about 5 us per byte, 7 per word; host polls.
// RQ6: sector erase ends within 15 s; host erase timeout sized to it.
// RQ7: program ends within 300 us byte, 360 us word; longer is failure.
// RQ8: device shows busy within 200 ns after the last command write.
// RQ9: program is four bus writes, or two in bypass; last carries target.
// RQ10: writes may be strobed by chip enable with write enable low.
// RQ11: during program, polling bit reads back complemented at program address.
// RQ12: main toggle bit toggles on every read during an operation, any address.
// RQ13: after program completes, the program address returns true data.
// RQ14: ready/busy output stays busy through the whole operation.
module fph_flash_host #(
	parameter int AW = 19,
	parameter int DW = 16,
	parameter int PROG_BYTE_MAX = fph_pkg::PROG_BYTE_MAX_CYC,
	parameter int PROG_WORD_MAX = fph_pkg::PROG_WORD_MAX_CYC,
	parameter int ERASE_MAX = fph_pkg::ERASE_MAX_CYC,
	parameter logic [AW-1:0] UNLOCK1_ADDR = 19'h00555,
	parameter logic [AW-1:0] UNLOCK2_ADDR = 19'h002AA,
	parameter logic [DW-1:0] CMD_UNLOCK1 = 16'h00AA,
	parameter logic [DW-1:0] CMD_UNLOCK2 = 16'h0055,
	parameter logic [DW-1:0] CMD_PROGRAM = 16'h00A0,
	parameter logic [DW-1:0] CMD_ERASE_SETUP = 16'h0080,
	parameter logic [DW-1:0] CMD_SECTOR_ERASE = 16'h0030
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	output logic [AW-1:0] o_flash_addr,
	output logic [DW-1:0] o_flash_dq,
	output logic o_flash_dq_oe,
	input wire logic [DW-1:0] i_flash_dq,
	output logic o_flash_ce_n,
	output logic o_flash_oe_n,
	output logic o_flash_we_n,
	output logic o_flash_byte_n,
	input wire logic i_ready_busy_n
);
	fph_pkg::fph_state_t state_reg, state_next;
	logic [fph_pkg::CTRL_W-1:0] ctrl_reg;
	logic [AW-1:0] addr_reg, fa_reg;
	logic [DW-1:0] data_reg, fd_reg, rd_reg;
	logic [fph_pkg::STAT_W-1:0] stat_reg, mask_reg, ev_set;
	logic [31:0] prdata_reg, rmux, tmo_reg, tmo_lim;
	logic [2:0] idx_reg, idx_next, last_idx, eff_idx;
	logic [2:0] cnt_reg;
	logic have_prev_reg;

	wire apb_setup = i_psel & ~i_penable;
	wire apb_access = i_psel & i_penable;
	wire wr_acc = apb_access & i_pwrite;
	wire rd_acc = apb_access & ~i_pwrite;
	wire mapped = (i_paddr == fph_pkg::REG_CTRL) | (i_paddr == fph_pkg::REG_ADDR)
		| (i_paddr == fph_pkg::REG_DATA) | (i_paddr == fph_pkg::REG_STAT)
		| (i_paddr == fph_pkg::REG_MASK) | (i_paddr == fph_pkg::REG_RDATA);
	wire idle = state_reg == fph_pkg::ST_IDLE;
	wire start = wr_acc & (i_paddr == fph_pkg::REG_CTRL) & idle;
	// the first write is set up on the start edge, before ctrl_reg holds the new order
	wire [fph_pkg::CTRL_W-1:0] ctrl_cur = start ? i_pwdata[fph_pkg::CTRL_W-1:0] : ctrl_reg;
	wire [1:0] op = ctrl_cur[fph_pkg::CTRL_OP_LSB +: 2];
	wire [1:0] start_op = i_pwdata[fph_pkg::CTRL_OP_LSB +: 2];
	wire bypass = ctrl_cur[fph_pkg::CTRL_BYPASS];
	wire ce_mode = ctrl_cur[fph_pkg::CTRL_CE_STROBE];
	wire word_mode = ctrl_cur[fph_pkg::CTRL_WORD];
	wire cnt_done = cnt_reg == 3'h0;
	wire wr_ph = (state_reg == fph_pkg::ST_WSETUP) | (state_reg == fph_pkg::ST_WSTROBE)
		| (state_reg == fph_pkg::ST_WRECOV);
	wire poll_ph = (state_reg == fph_pkg::ST_BUSYWAIT) | (state_reg == fph_pkg::ST_RSTROBE)
		| (state_reg == fph_pkg::ST_RGAP);
	wire timed_out = poll_ph & (op != fph_pkg::OP_READ) & (tmo_reg == tmo_lim - 32'h1);
	wire rd_end = (state_reg == fph_pkg::ST_RSTROBE) & cnt_done;
	// completion: two successive status reads with the toggle bit at rest
	wire toggle_still = have_prev_reg
		& (i_flash_dq[fph_pkg::TOGGLE_BIT] == rd_reg[fph_pkg::TOGGLE_BIT]);
	wire finish = rd_end & ((op == fph_pkg::OP_READ) | toggle_still);
	wire [DW-1:0] byte_mask = word_mode ? {DW{1'b1}} : DW'(16'h00FF);
	wire [DW-1:0] expect_val = (op == fph_pkg::OP_PROG) ? data_reg : {DW{1'b1}};
	wire mismatch = finish & (op != fph_pkg::OP_READ)
		& (((i_flash_dq ^ expect_val) & byte_mask) != '0);
	wire wr_last_end = (state_reg == fph_pkg::ST_WRECOV) & cnt_done & (idx_reg == last_idx);

	assign tmo_lim = (op == fph_pkg::OP_ERASE) ? 32'(ERASE_MAX)
		: (word_mode ? 32'(PROG_WORD_MAX) : 32'(PROG_BYTE_MAX)); // [RQ6] [RQ7]
	// bypass skips the two unlock writes of the program sequence
	assign last_idx = (op == fph_pkg::OP_ERASE) ? 3'h5 : (op == fph_pkg::OP_WRITE) ? 3'h0
		: (bypass ? 3'h1 : 3'h3); // [RQ9]
	assign eff_idx = (op == fph_pkg::OP_PROG && bypass) ? idx_next + 3'h2 : idx_next;

	function automatic logic [1:0] seq_kind(input logic [1:0] o, input logic [2:0] i);
		seq_kind = fph_pkg::AK_TARGET;
		if (o != fph_pkg::OP_WRITE && !(o == fph_pkg::OP_PROG && i == 3'h3) && i != 3'h5)
			seq_kind = (i == 3'h1 || i == 3'h4) ? fph_pkg::AK_UNLOCK2 : fph_pkg::AK_UNLOCK1;
	endfunction

	function automatic logic [DW-1:0] seq_data(input logic [1:0] o, input logic [2:0] i);
		unique case (i)
			3'h0, 3'h3: seq_data = (o == fph_pkg::OP_PROG && i == 3'h3) ? data_reg
				: CMD_UNLOCK1;
			3'h1, 3'h4: seq_data = CMD_UNLOCK2;
			3'h2: seq_data = (o == fph_pkg::OP_ERASE) ? CMD_ERASE_SETUP : CMD_PROGRAM;
			default: seq_data = CMD_SECTOR_ERASE;
		endcase
		if (o == fph_pkg::OP_WRITE)
			seq_data = data_reg;
	endfunction

	// byte mode puts the extra low address line below the word address
	function automatic logic [AW-1:0] pick_addr(input logic [1:0] k);
		logic [AW-1:0] a;
		a = (k == fph_pkg::AK_UNLOCK1) ? UNLOCK1_ADDR : UNLOCK2_ADDR;
		if (!word_mode)
			a = {a[AW-2:0], 1'b0};
		pick_addr = (k == fph_pkg::AK_TARGET) ? addr_reg : a;
		if (op == fph_pkg::OP_WRITE && ctrl_cur[fph_pkg::CTRL_PROTECT]) begin
			pick_addr[fph_pkg::PROT_HIGH_BIT] = 1'b1; // [RQ4]
			pick_addr[fph_pkg::PROT_LOW_BIT] = 1'b0; // [RQ4]
			pick_addr[fph_pkg::PROT_SEL_BIT] = ctrl_cur[fph_pkg::CTRL_UNPROTECT]; // [RQ4]
		end
	endfunction

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		unique case (state_reg)
			fph_pkg::ST_IDLE: begin
				idx_next = 3'h0;
				if (start)
					state_next = (start_op == fph_pkg::OP_READ) ? fph_pkg::ST_RSTROBE
						: fph_pkg::ST_WSETUP;
			end
			fph_pkg::ST_WSETUP: state_next = fph_pkg::ST_WSTROBE;
			fph_pkg::ST_WSTROBE: if (cnt_done) state_next = fph_pkg::ST_WRECOV;
			fph_pkg::ST_WRECOV: begin
				if (wr_last_end)
					state_next = (op == fph_pkg::OP_WRITE) ? fph_pkg::ST_IDLE
						: fph_pkg::ST_BUSYWAIT;
				else if (cnt_done) begin
					state_next = fph_pkg::ST_WSETUP;
					idx_next = idx_reg + 3'h1;
				end
			end
			fph_pkg::ST_BUSYWAIT: if (cnt_done) state_next = fph_pkg::ST_RSTROBE;
			fph_pkg::ST_RSTROBE: if (cnt_done)
				state_next = finish ? fph_pkg::ST_IDLE : fph_pkg::ST_RGAP;
			fph_pkg::ST_RGAP: if (cnt_done) state_next = fph_pkg::ST_RSTROBE;
		endcase
		// poll is given up once the worst-case time has passed
		if (timed_out)
			state_next = fph_pkg::ST_IDLE; // [RQ6] [RQ7]
	end

	assign ev_set[fph_pkg::STAT_DONE] = finish | (wr_last_end & (op == fph_pkg::OP_WRITE));
	assign ev_set[fph_pkg::STAT_TMO] = timed_out;
	assign ev_set[fph_pkg::STAT_MISMATCH] = mismatch; // [RQ13]

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= fph_pkg::ST_IDLE;
			idx_reg <= 3'h0;
			cnt_reg <= 3'h0;
			tmo_reg <= 32'h0;
			have_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			if (state_next == fph_pkg::ST_WSTROBE && state_reg != state_next)
				cnt_reg <= 3'(fph_pkg::WP_CYC - 1);
			else if (state_next == fph_pkg::ST_WRECOV && state_reg != state_next)
				cnt_reg <= 3'(fph_pkg::WPH_CYC - 1);
			else if (state_next == fph_pkg::ST_BUSYWAIT && state_reg != state_next)
				cnt_reg <= 3'(fph_pkg::BUSY_CYC - 1); // [RQ8]
			else if (state_next == fph_pkg::ST_RSTROBE && state_reg != state_next)
				cnt_reg <= 3'(fph_pkg::ACC_CYC - 1);
			else if (state_next == fph_pkg::ST_RGAP && state_reg != state_next)
				cnt_reg <= 3'(fph_pkg::OEH_CYC - 1);
			else if (!cnt_done)
				cnt_reg <= cnt_reg - 3'h1;
			// no fixed wait is assumed: only the timeout bounds the poll
			tmo_reg <= poll_ph ? tmo_reg + 32'h1 : 32'h0; // [RQ5]
			if (state_reg == fph_pkg::ST_BUSYWAIT)
				have_prev_reg <= 1'b0;
			else if (rd_end)
				have_prev_reg <= 1'b1; // [RQ12]
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fa_reg <= '0;
			fd_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (state_next == fph_pkg::ST_WSETUP) begin
				fa_reg <= pick_addr(seq_kind(op, eff_idx)); // [RQ9]
				fd_reg <= seq_data(op, eff_idx);
			end else if (state_next == fph_pkg::ST_RSTROBE && start)
				fa_reg <= addr_reg;
			else if (state_reg == fph_pkg::ST_BUSYWAIT)
				fa_reg <= addr_reg; // [RQ11] [RQ13]
			if (rd_end)
				rd_reg <= i_flash_dq;
		end
	end

	// register file
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= '0;
			addr_reg <= '0;
			data_reg <= '0;
			mask_reg <= '0;
			stat_reg <= '0;
			prdata_reg <= 32'h0;
		end else begin
			if (start)
				ctrl_reg <= i_pwdata[fph_pkg::CTRL_W-1:0];
			if (wr_acc && idle && i_paddr == fph_pkg::REG_ADDR)
				addr_reg <= i_pwdata[AW-1:0];
			if (wr_acc && idle && i_paddr == fph_pkg::REG_DATA)
				data_reg <= i_pwdata[DW-1:0];
			if (wr_acc && i_paddr == fph_pkg::REG_MASK)
				mask_reg <= i_pwdata[fph_pkg::STAT_W-1:0];
			// only bits captured for the reader are cleared; later events survive the read
			if (rd_acc && i_paddr == fph_pkg::REG_STAT)
				stat_reg <= (stat_reg & ~prdata_reg[fph_pkg::STAT_W-1:0]) | ev_set;
			else
				stat_reg <= stat_reg | ev_set;
			if (apb_setup)
				prdata_reg <= rmux;
		end
	end

	always_comb begin
		rmux = 32'h0;
		unique case (i_paddr)
			fph_pkg::REG_CTRL: rmux[fph_pkg::CTRL_W-1:0] = ctrl_reg;
			fph_pkg::REG_ADDR: rmux[AW-1:0] = addr_reg;
			fph_pkg::REG_DATA: rmux[DW-1:0] = data_reg;
			fph_pkg::REG_STAT: begin
				rmux[fph_pkg::STAT_W-1:0] = stat_reg;
				rmux[fph_pkg::STAT_BUSY] = ~idle;
				rmux[fph_pkg::STAT_RDY] = i_ready_busy_n; // [RQ14]
			end
			fph_pkg::REG_MASK: rmux[fph_pkg::STAT_W-1:0] = mask_reg;
			fph_pkg::REG_RDATA: rmux[DW-1:0] = rd_reg;
			default: rmux = 32'h0;
		endcase
	end

	assign o_prdata = prdata_reg;
	assign o_pready = 1'b1;
	assign o_pslverr = apb_access & ~mapped;
	assign o_irq = |(stat_reg & mask_reg);
	assign o_flash_addr = fa_reg;
	assign o_flash_dq = fd_reg;
	assign o_flash_dq_oe = wr_ph;
	assign o_flash_byte_n = word_mode;
	// chip-enable strobing keeps write enable low and pulses chip enable
	assign o_flash_we_n = ~(ce_mode ? (wr_ph & state_reg != fph_pkg::ST_WRECOV)
		: state_reg == fph_pkg::ST_WSTROBE); // [RQ10]
	assign o_flash_ce_n = ~(ce_mode ? (state_reg == fph_pkg::ST_WSTROBE
		| state_reg == fph_pkg::ST_RSTROBE)
		: ((wr_ph & state_reg != fph_pkg::ST_WRECOV) | state_reg == fph_pkg::ST_RSTROBE
		| state_reg == fph_pkg::ST_RGAP)); // [RQ10] [RQ3]
	assign o_flash_oe_n = ~(state_reg == fph_pkg::ST_RSTROBE); // [RQ3]

	a_no_strobe_clash: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ10]
		!(!o_flash_we_n && !o_flash_oe_n)) else $error("write and output enable both low");
	a_ce_mode_we: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ10]
		(ce_mode && state_reg == fph_pkg::ST_WSTROBE) |-> !o_flash_we_n && !o_flash_ce_n)
		else $error("chip enable strobe without write enable low");
	a_busy_wait_len: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ8]
		(wr_last_end && op != fph_pkg::OP_WRITE) |=> (state_reg == fph_pkg::ST_BUSYWAIT)[*4]
		##1 state_reg == fph_pkg::ST_RSTROBE) else $error("busy wait not 200 ns");
	a_oe_cycles: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ3]
		(rd_end && !finish && !timed_out) |=> o_flash_oe_n ##1 !o_flash_oe_n)
		else $error("output enable not cycled between status reads");
	a_poll_addr: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ11]
		(state_reg == fph_pkg::ST_RSTROBE && op == fph_pkg::OP_PROG) |-> fa_reg == addr_reg)
		else $error("status read away from program address");
	a_prot_addr: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ4]
		(wr_ph && op == fph_pkg::OP_WRITE && ctrl_reg[fph_pkg::CTRL_PROTECT])
		|-> fa_reg[1:0] == 2'h2 && fa_reg[6] == ctrl_reg[fph_pkg::CTRL_UNPROTECT])
		else $error("protect address lines wrong");
	a_prog_len: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ9]
		(wr_last_end && op == fph_pkg::OP_PROG) |-> idx_reg == (bypass ? 3'h1 : 3'h3)
		&& fd_reg == data_reg && fa_reg == addr_reg) else $error("program sequence wrong");
	a_tmo_bound: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ7]
		poll_ph |-> tmo_reg < tmo_lim) else $error("poll ran past worst-case time");
	a_done_flag: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RQ12]
		finish |=> stat_reg[fph_pkg::STAT_DONE] && idle) else $error("completion not flagged");
	a_irq_follow: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		$rose(stat_reg[fph_pkg::STAT_TMO]) && mask_reg[fph_pkg::STAT_TMO] |-> o_irq)
		else $error("masked-in timeout gives no interrupt");

	c_program: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		finish && op == fph_pkg::OP_PROG);
	c_bypass_ce: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		wr_last_end && bypass && ce_mode);
	c_erase: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		finish && op == fph_pkg::OP_ERASE);
	c_timeout: cover property (@(posedge i_clock) disable iff (!i_rst_b) timed_out);
endmodule

/* bench/fph_flash_model.sv */
// behavioural parallel nor flash answering the host controller's pins
`timescale 1ns/10ps
module fph_flash_model (
	input wire logic [18:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_byte_n,
	input wire logic [31:0] i_busy_ns,
	output logic [15:0] o_dq,
	output logic o_ready_busy_n,
	output logic [18:0] o_last_addr
);
	logic [15:0] mem [0:255];
	logic [15:0] rd_q;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] prog_val = 16'h0000;
	logic [7:0] prog_idx = 8'h00;
	logic busy = 1'b0;
	logic erasing = 1'b0;
	logic toggle = 1'b0;
	logic bypass = 1'b0;
	int step = 0;
	wire wr_strobe = i_ce_n | i_we_n;
	wire rd_strobe = i_ce_n | i_oe_n;
	wire [10:0] key = i_byte_n ? i_addr[10:0] : i_addr[11:1];
	wire [7:0] cd = i_dq[7:0];
	wire unl1 = key == 11'h555;
	wire unl2 = key == 11'h2AA;
	initial begin
		o_ready_busy_n = 1'b1;
		o_last_addr = 19'h00000;
		for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
	end
	// a write ends on whichever strobe rises first, so both forms decode alike
	always @(posedge wr_strobe) begin
		o_last_addr <= i_addr;
		step <= 0;
		if (busy) begin
			step <= step;
		end else if (step == 3 || step == 10) begin
			prog_idx <= i_addr[7:0];
			prog_val <= i_byte_n ? i_dq : {8'hFF, cd};
			busy <= 1'b1;
		end else if (step == 6 && cd == 8'h30) begin
			erasing <= 1'b1;
			busy <= 1'b1;
		end else if (bypass && step == 0) begin
			if (cd == 8'hA0) step <= 10;
			if (cd == 8'h90) step <= 20;
		end else if (step == 20) begin
			bypass <= (cd != 8'h00);
		end else if ((step == 0 || step == 4) && unl1 && cd == 8'hAA) begin
			step <= step + 1;
		end else if ((step == 1 || step == 5) && unl2 && cd == 8'h55) begin
			step <= step + 1;
		end else if (step == 2 && unl1) begin
			if (cd == 8'hA0) step <= 3;
			if (cd == 8'h80) step <= 4;
			if (cd == 8'h20) bypass <= 1'b1;
		end
	end
	// duration comes from the bench so the same model can be quick, slow or stuck
	always @(posedge busy) begin
		o_ready_busy_n = 1'b0;
		// end off the clock edge so the host never samples mid-update
		#(i_busy_ns + 32'd10);
		for (int i = 0; i < 256; i++) begin
			if (erasing) mem[i] = 16'h0000;
			if (erasing) mem[i] = 16'hFFFF;
		end
		if (!erasing) mem[prog_idx] = mem[prog_idx] & prog_val;
		erasing = 1'b0;
		busy = 1'b0;
		o_ready_busy_n = 1'b1;
	end
	always_comb begin
		rd_q = mem[i_addr[7:0]];
		if (busy) begin
			rd_q = 16'h0000;  // no erase is ever suspended, so that bit holds still
			rd_q[7] = erasing ? 1'b0 : ~prog_val[7];
			rd_q[6] = toggle;
		end
	end
	always @(posedge rd_strobe) begin
		if (busy) toggle <= ~toggle;
		last_q <= rd_q;
	end
	// a released bus shows the inverse of its last value, never a helpful copy
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd_q : ~last_q;
endmodule

/* bench/fph_flash_host_tb.sv */
// self-checking bench for the flash program/erase host controller
`timescale 1ns/10ps
module fph_flash_host_tb;
	localparam int WORD = 1 << fph_pkg::CTRL_WORD;
	localparam int BYP = 1 << fph_pkg::CTRL_BYPASS;
	localparam int CES = 1 << fph_pkg::CTRL_CE_STROBE;
	localparam int PROT = 1 << fph_pkg::CTRL_PROTECT;
	localparam int UNPR = 1 << fph_pkg::CTRL_UNPROTECT;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	localparam logic [32:0] SMSK = 33'h1_0000_0307;
	localparam logic [7:0] ZREGS [4] = '{fph_pkg::REG_ADDR, fph_pkg::REG_DATA,
		fph_pkg::REG_MASK, fph_pkg::REG_RDATA};
	logic [32:0] cur_msk;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd_val;
	logic pready, pslverr, irq, ce_n, oe_n, we_n, byte_n, dq_oe, rb_n;
	logic [18:0] faddr, last_addr;
	logic [15:0] dq_out, dq_in, d;
	logic [31:0] busy_ns = 32'd1500;
	logic [15:0] lfsr = 16'd11918;
	logic [32:0] exp_q[$], msk_q[$];
	int err_total = 0, check_count = 0, cycles = 0;
	always #25 i_clock = ~i_clock;
	// word limit chosen so the timeout lands inside a read strobe, not in its gap
	fph_flash_host #(.PROG_BYTE_MAX(400), .PROG_WORD_MAX(402), .ERASE_MAX(2000)) dut (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_flash_addr(faddr),
		.o_flash_dq(dq_out), .o_flash_dq_oe(dq_oe), .i_flash_dq(dq_in), .o_flash_ce_n(ce_n),
		.o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_byte_n(byte_n),
		.i_ready_busy_n(rb_n));
	fph_flash_model flash (.i_addr(faddr), .i_dq(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_byte_n(byte_n), .i_busy_ns(busy_ns), .o_dq(dq_in),
		.o_ready_busy_n(rb_n), .o_last_addr(last_addr));
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge i_clock);
		penable <= 1'b1;
		do @(posedge i_clock); while (pready !== 1'b1);
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] exp, input logic [32:0] msk);
		exp_q.push_back(exp);
		msk_q.push_back(msk);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// polling reads also clear any late sticky flag before the next operation
	task automatic settle;
		do rd(fph_pkg::REG_STAT, 33'h0, 33'h0); while (rd_val[fph_pkg::STAT_BUSY] !== 1'b0);
		rd(fph_pkg::REG_STAT, 33'h0, 33'h0);
	endtask
	task automatic run_op(input int ctrl, input logic [32:0] exp, input logic [32:0] msk);
		apb(1'b1, fph_pkg::REG_CTRL, 32'(ctrl));
		while (rb_n !== 1'b0) @(posedge i_clock);
		rd(fph_pkg::REG_STAT, 33'h100, SMSK);
		while (irq !== 1'b1) @(posedge i_clock);
		rd(fph_pkg::REG_STAT, exp, msk);
		check("irq after status read", 33'h0, {32'h0, irq});
	endtask
	task automatic raw(input logic [31:0] a, input logic [31:0] v, input int ctrl);
		apb(1'b1, fph_pkg::REG_ADDR, a);
		apb(1'b1, fph_pkg::REG_DATA, v);
		apb(1'b1, fph_pkg::REG_CTRL, 32'(ctrl | fph_pkg::OP_WRITE));
		settle();
	endtask
	task automatic fread(input logic [31:0] a, input int ctrl, input logic [32:0] exp);
		apb(1'b1, fph_pkg::REG_ADDR, a);
		apb(1'b1, fph_pkg::REG_CTRL, 32'(ctrl | fph_pkg::OP_READ));
		settle();
		rd(fph_pkg::REG_RDATA, exp, (ctrl & WORD) != 0 ? 33'h1_0000_FFFF : 33'h1_0000_00FF);
	endtask
	always @(posedge i_clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) check("unexpected read", 33'h0, ALL);
			else begin
				cur_msk = msk_q.pop_front();
				check("apb read", exp_q.pop_front() & cur_msk, {pslverr, prdata} & cur_msk);
			end
		end
		if (!we_n || !oe_n)
			check("data bus direction", {32'h0, oe_n}, {32'h0, dq_oe});
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		rd(fph_pkg::REG_STAT, 33'h200, ALL);
		foreach (ZREGS[i])
			rd(ZREGS[i], 33'h0, ALL);
		rd(8'h18, 33'h1_0000_0000, ALL);
		apb(1'b1, fph_pkg::REG_MASK, 32'h0000_0007);
		busy_ns <= 32'd5000;
		apb(1'b1, fph_pkg::REG_ADDR, 32'h0000_0100);
		run_op(fph_pkg::OP_ERASE | WORD, 33'h201, SMSK);
		fread(32'h10, WORD, 33'hFFFF);
		busy_ns <= 32'd1500;
		lfsr = lfsr_next(lfsr);
		d = lfsr;
		apb(1'b1, fph_pkg::REG_DATA, {16'h0, d});
		run_op(fph_pkg::OP_PROG | WORD, 33'h201, SMSK);
		fread(32'h10, WORD, {17'h0, d});
		apb(1'b1, fph_pkg::REG_DATA, {16'h0, ~d});
		run_op(fph_pkg::OP_PROG | WORD, 33'h204, 33'h1_0000_0306);
		raw(32'hAAA, 32'hAA, 0);
		raw(32'h555, 32'h55, CES);
		raw(32'hAAA, 32'h20, 0);
		lfsr = lfsr_next(lfsr);
		apb(1'b1, fph_pkg::REG_ADDR, 32'h0000_0020);
		apb(1'b1, fph_pkg::REG_DATA, {24'h0, lfsr[7:0]});
		run_op(fph_pkg::OP_PROG | BYP | CES, 33'h201, SMSK);
		fread(32'h20, 0, {25'h0, lfsr[7:0]});
		raw(32'h0, 32'h90, 0);
		raw(32'h0, 32'h00, 0);
		for (int u = 0; u < 2; u++) begin
			raw(32'h0, 32'h60, PROT | (u != 0 ? UNPR : 0));
			check("protect address bits", {30'h0, u[0], 2'b10},
				{30'h0, last_addr[fph_pkg::PROT_SEL_BIT], last_addr[1:0]});
		end
		busy_ns <= 32'd1000000;
		apb(1'b1, fph_pkg::REG_ADDR, 32'h0000_0030);
		run_op(fph_pkg::OP_PROG | WORD, 33'h002, 33'h1_0000_0102);
		complete_run();
	end
endmodule
